// File: idle_reset_consts.svh
// Register offsets, field positions, reset values and timing counts
`ifndef IDLE_RESET_CONSTS_SVH
`define IDLE_RESET_CONSTS_SVH
`define ADDR_STACK_PTR      12'hffc
`define ADDR_CLOCK_MODE     12'hfd3
`define ADDR_WATCHDOG       12'hfd1
`define ADDR_RESET_CAUSE    12'hfd0
`define CM_IDLE_BIT         7
`define CM_PRI_READY_BIT    3
`define CM_SECONDARY_RUN_MODE_BIT      2
`define CM_SEL_LO           0
`define CS_INTPRI_BIT       7
`define RC_RSTINS_BIT       4
`define RC_WDOG_BIT         3
`define RC_PWRDN_BIT        2
`define RC_POR_BIT          1
`define RC_BROWN_BIT        0
`define SP_FULL_BIT         7
`define SP_UNF_BIT          6
`define SEL_PRIMARY         2'h0
`define SEL_SECONDARY       2'h1
`define PC_RESET            21'h000000
`define PC_VEC_HIGH         21'h000008
`define PC_VEC_LOW          21'h000018
`define PC_STEP             21'h000002
`define SWITCH_DELAY_NS     20
`define CLOCK_PERIOD_NS     5
`define SWITCH_DELAY_CYC    ((`SWITCH_DELAY_NS + `CLOCK_PERIOD_NS - 1) / `CLOCK_PERIOD_NS)
`endif

// File: idle_reset_pkg.sv
// Types shared by the idle mode and reset cause logic
package idle_reset_pkg;
    typedef enum logic [3:0]
    {
        ST_RUN  = 4'h1,
        ST_PIDL = 4'h2,
        ST_SIDL = 4'h4,
        ST_WAKE = 4'h8
    } power_state_e;
    typedef logic [20:0] pc_t;
    typedef logic [7:0]  byte_t;
endpackage

// File: reg_port_if.sv
// Register access signals between the top and the register file
interface reg_port_if;
    logic [11:0] addr;
    logic        wrEn;
    logic [7:0]  wrData;
    logic [7:0]  rdData;
    modport top  (output addr, output wrEn, output wrData, input rdData);
    modport regs (input addr, input wrEn, input wrData, output rdData);
endinterface

// File: clock_mode_regs.sv
// Clock mode control register with idle and clock select fields
`include "idle_reset_consts.svh"
module clock_mode_regs
    import idle_reset_pkg::*;
(
    input  wire logic   clock,
    input  wire logic   nrst,
    reg_port_if.regs    bus,
    input  wire logic   priReady,
    input  wire logic   secRunning,
    output logic        idleOnHalt,
    output logic [1:0]  clockSelect
);
    byte_t modeReg;

    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
            modeReg <= 8'h00;
        else if (bus.wrEn && bus.addr == `ADDR_CLOCK_MODE)
            modeReg <= bus.wrData;
    end

    assign idleOnHalt  = modeReg[`CM_IDLE_BIT];
    assign clockSelect = modeReg[`CM_SEL_LO +: 2];
    assign bus.rdData  = {modeReg[7:4], priReady, secRunning, modeReg[1:0]};
endmodule

// File: idle_mode_and_reset_cause_logic.sv
// Idle modes, clock source switching, wake delay and reset cause flags
// Notes on behaviour
// - Primary idle halts CPU, primary clock keeps running for peripherals.
// - Primary ready flag stays set during and after primary idle.
// - Primary idle wake clocks CPU from primary after switch delay.
// - Wake leaves idle bit and clock select unchanged.
// - Secondary idle halts CPU; peripherals run on secondary oscillator.
// - Switch to secondary stops primary, clears ready, sets running flag.
// - Secondary idle wake keeps oscillator; CPU resumes after switch delay.
// - Halt ignored for secondary idle when secondary enable is clear.
// - Peripheral clocks held off in secondary idle until secondary oscillator has started.
// - Only designated registers take reset values; others keep theirs.
// - Power-on: PC zero, instruction, watchdog, power-down flags set; others cleared.
// - Reset instruction: PC zero, clear its own flag only.
// - Brown-out: PC zero, set instruction, watchdog, power-down flags; clear brown-out flag.
// - Pin reset in low-power run: PC zero, set watchdog flag.
// - Pin reset in idle or sleep: PC zero, set watchdog flag, clear power-down flag.
// - Watchdog in full or run mode: PC zero, clear watchdog flag.
// - Pin reset in full power: PC zero, flags unchanged.
// - Stack fault: set flag, reset if enabled; underflow loads PC zero regardless.
// - Watchdog in idle or sleep wakes at PC plus 2, clears watchdog and power-down flags.
// - Interrupt wake clears PD, PC plus 2 or priority vector.
`include "idle_reset_consts.svh"
module idle_mode_and_reset_cause_logic
    import idle_reset_pkg::*;
(
    input  wire logic   clock,
    input  wire logic   nrst,
    input  wire logic   powerOnReset,
    input  wire logic   brownoutReset,
    input  wire logic   externalResetPin,
    input  wire logic   resetInstruction,
    input  wire logic   watchdogTimeout,
    input  wire logic   stackOverflow,
    input  wire logic   stackUnderflow,
    input  wire logic   stackFaultResetEnable,
    input  wire logic   haltInstruction,
    input  wire logic   sleepMode,
    input  wire logic   wakeInterrupt,
    input  wire logic   highPriorityIntEnable,
    input  wire logic   lowPriorityIntEnable,
    input  wire logic   secondaryOscEnable,
    input  wire logic   secondaryOscStarted,
    input  wire logic   primaryOscStable,
    input  wire pc_t    currentPc,
    input  wire logic   regWrite,
    input  wire logic   regRead,
    input  wire logic [11:0] regAddr,
    input  wire byte_t  regWrData,
    output byte_t       regRdData,
    output logic        cpuRun,
    output logic        peripheralClockOn,
    output logic        peripheralOnSecondary,
    output logic        primaryOscOn,
    output logic        loadPc,
    output pc_t         pcValue
);
    reg_port_if port ();
    power_state_e state_reg;
    power_state_e state_next;
    logic       idleOnHalt;
    logic [1:0] clockSelect;
    logic       priReady_reg;
    logic       secRunning_reg;
    logic [7:0] delayCount_reg;
    logic [4:0] cause_reg;
    logic       stackFull_reg;
    logic       stackUnf_reg;
    byte_t      stackPtr_reg;
    byte_t      watchdog_reg;
    byte_t      rdData_reg;
    logic       loadPc_reg;
    pc_t        pcValue_reg;
    logic       inIdle;
    logic       anyReset;
    logic       wake;
    logic       enterPri;
    logic       enterSec;
    logic       sleepWake;

    function automatic logic isWrite(input logic [11:0] a);
        isWrite = regWrite && regAddr == a;
    endfunction

    assign port.addr   = regAddr;
    assign port.wrEn   = regWrite;
    assign port.wrData = regWrData;

    clock_mode_regs clock_mode_regs_i
    (
        .clock       (clock),
        .nrst        (nrst),
        .bus         (port),
        .priReady    (priReady_reg),
        .secRunning  (secRunning_reg),
        .idleOnHalt  (idleOnHalt),
        .clockSelect (clockSelect)
    );

    // Events that restart at the reset vector
    assign inIdle   = (state_reg == ST_PIDL) || (state_reg == ST_SIDL);
    assign anyReset = powerOnReset || brownoutReset || externalResetPin || resetInstruction
                    || (watchdogTimeout && !inIdle && !sleepMode)
                    || ((stackOverflow || stackUnderflow) && stackFaultResetEnable);
    assign wake     = inIdle && (wakeInterrupt || watchdogTimeout);
    // Sleep has no clock switch, so its wake loads the pc at once
    assign sleepWake = sleepMode && !inIdle && (wakeInterrupt || watchdogTimeout);
    assign enterPri = haltInstruction && idleOnHalt && clockSelect == `SEL_PRIMARY;
    assign enterSec = haltInstruction && idleOnHalt && clockSelect == `SEL_SECONDARY
                    && secondaryOscEnable;

    // Power state: run, primary idle, secondary idle, wake delay
    always_comb
    begin
        state_next = state_reg;
        case (state_reg)
            ST_RUN:
                if (enterPri)
                    state_next = ST_PIDL;
                else if (enterSec)
                    state_next = ST_SIDL;
            ST_PIDL, ST_SIDL:
                if (wake)
                    state_next = ST_WAKE;
            ST_WAKE:
                if (delayCount_reg == 8'h00)
                    state_next = ST_RUN;
            default:
                state_next = ST_RUN;
        endcase
        if (anyReset)
            state_next = ST_RUN;
    end

    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
            state_reg <= ST_RUN;
        else
            state_reg <= state_next;
    end

    // Counts the clock switch delay after an idle wake
    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
            delayCount_reg <= 8'h00;
        else if (wake)
            delayCount_reg <= 8'(`SWITCH_DELAY_CYC - 1);
        else if (state_reg == ST_WAKE && delayCount_reg != 8'h00)
            delayCount_reg <= delayCount_reg - 8'h01;
    end

    // Clock source flags follow the selected source
    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
        begin
            priReady_reg   <= 1'b0;
            secRunning_reg <= 1'b0;
        end
        else if (clockSelect == `SEL_SECONDARY && secondaryOscEnable)
        begin
            priReady_reg   <= 1'b0;
            secRunning_reg <= 1'b1;
        end
        else
        begin
            priReady_reg   <= primaryOscStable;
            secRunning_reg <= 1'b0;
        end
    end

    assign primaryOscOn          = !(clockSelect == `SEL_SECONDARY && secondaryOscEnable);
    assign cpuRun                = state_reg == ST_RUN;
    assign peripheralOnSecondary = secRunning_reg;
    assign peripheralClockOn     = !(state_reg == ST_SIDL && !secondaryOscStarted);

    // Reset cause flags, high bit first: instruction, watchdog, power-down, power-on, brown-out
    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
        begin
            cause_reg     <= 5'h1c;
            stackFull_reg <= 1'b0;
            stackUnf_reg  <= 1'b0;
        end
        else if (powerOnReset)
        begin
            cause_reg     <= 5'h1c;
            stackFull_reg <= 1'b0;
            stackUnf_reg  <= 1'b0;
        end
        else if (brownoutReset)
        begin
            cause_reg[`RC_RSTINS_BIT] <= 1'b1;
            cause_reg[`RC_WDOG_BIT]   <= 1'b1;
            cause_reg[`RC_PWRDN_BIT]  <= 1'b1;
            cause_reg[`RC_BROWN_BIT]  <= 1'b0;
        end
        else
        begin
            if (isWrite(`ADDR_RESET_CAUSE))
            begin
                cause_reg[`RC_RSTINS_BIT] <= regWrData[`RC_RSTINS_BIT];
                cause_reg[`RC_POR_BIT]    <= regWrData[`RC_POR_BIT];
                cause_reg[`RC_BROWN_BIT]  <= regWrData[`RC_BROWN_BIT];
            end
            if (resetInstruction)
                cause_reg[`RC_RSTINS_BIT] <= 1'b0;
            if (externalResetPin && (inIdle || sleepMode))
            begin
                cause_reg[`RC_WDOG_BIT]  <= 1'b1;
                cause_reg[`RC_PWRDN_BIT] <= 1'b0;
            end
            else if (externalResetPin && clockSelect != `SEL_PRIMARY)
                cause_reg[`RC_WDOG_BIT] <= 1'b1;
            else if (watchdogTimeout && (inIdle || sleepMode))
            begin
                cause_reg[`RC_WDOG_BIT]  <= 1'b0;
                cause_reg[`RC_PWRDN_BIT] <= 1'b0;
            end
            else if (watchdogTimeout)
                cause_reg[`RC_WDOG_BIT] <= 1'b0;
            else if (wakeInterrupt && (inIdle || sleepMode))
                cause_reg[`RC_PWRDN_BIT] <= 1'b0;
            if (isWrite(`ADDR_STACK_PTR))
            begin
                stackFull_reg <= regWrData[`SP_FULL_BIT];
                stackUnf_reg  <= regWrData[`SP_UNF_BIT];
            end
            if (stackOverflow)
                stackFull_reg <= 1'b1;
            if (stackUnderflow)
                stackUnf_reg  <= 1'b1;
        end
    end

    // Plain storage registers are not touched by the reset causes
    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
        begin
            stackPtr_reg <= 8'h00;
            watchdog_reg <= 8'h00;
        end
        else
        begin
            if (isWrite(`ADDR_STACK_PTR))
                stackPtr_reg <= {3'h0, regWrData[4:0]};
            if (isWrite(`ADDR_WATCHDOG))
                watchdog_reg <= regWrData;
        end
    end

    // Program counter load on reset or wake
    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
        begin
            loadPc_reg  <= 1'b0;
            pcValue_reg <= `PC_RESET;
        end
        else
        begin
            loadPc_reg <= anyReset || (state_reg == ST_WAKE && delayCount_reg == 8'h00) || sleepWake
                        || (stackUnderflow && !stackFaultResetEnable);
            if (anyReset)
                pcValue_reg <= `PC_RESET;
            else if (stackUnderflow && !stackFaultResetEnable)
                pcValue_reg <= `PC_RESET;
            else if ((wake || sleepWake) && wakeInterrupt && highPriorityIntEnable)
                pcValue_reg <= `PC_VEC_HIGH;
            else if ((wake || sleepWake) && wakeInterrupt && lowPriorityIntEnable)
                pcValue_reg <= `PC_VEC_LOW;
            else if (wake || sleepWake)
                pcValue_reg <= currentPc + `PC_STEP;
        end
    end

    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
            rdData_reg <= 8'h00;
        else if (regRead)
        begin
            case (regAddr)
                `ADDR_CLOCK_MODE:  rdData_reg <= port.rdData;
                `ADDR_WATCHDOG:    rdData_reg <= watchdog_reg;
                `ADDR_RESET_CAUSE: rdData_reg <= {3'h0, cause_reg};
                `ADDR_STACK_PTR:   rdData_reg <= {stackFull_reg, stackUnf_reg, stackPtr_reg[5:0]};
                default:           rdData_reg <= 8'h00;
            endcase
        end
    end

    assign regRdData = rdData_reg;
    assign loadPc    = loadPc_reg;
    assign pcValue   = pcValue_reg;
endmodule

// File: idle_reset_checker.sv
// Port-level assertions for the idle mode and reset cause logic
`include "idle_reset_consts.svh"
module idle_reset_checker
    import idle_reset_pkg::*;
(
    input wire logic clock,
    input wire logic nrst,
    input wire logic powerOnReset,
    input wire logic brownoutReset,
    input wire logic externalResetPin,
    input wire logic resetInstruction,
    input wire logic watchdogTimeout,
    input wire logic stackOverflow,
    input wire logic stackUnderflow,
    input wire logic stackFaultResetEnable,
    input wire logic wakeInterrupt,
    input wire logic highPriorityIntEnable,
    input wire logic lowPriorityIntEnable,
    input wire logic secondaryOscStarted,
    input wire pc_t  currentPc,
    input wire logic cpuRun,
    input wire logic peripheralClockOn,
    input wire logic peripheralOnSecondary,
    input wire logic primaryOscOn,
    input wire logic loadPc,
    input wire pc_t  pcValue
);
    timeunit 1ns;
    timeprecision 1ps;
    logic quiet;
    assign quiet = !(powerOnReset || brownoutReset || externalResetPin || resetInstruction
                   || stackOverflow || stackUnderflow);
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!nrst);
    property p_wake_delay;
        wakeInterrupt && !cpuRun && quiet |=> !loadPc [*4] ##1 (loadPc && cpuRun);
    endproperty
    a_wake_delay: assert property (p_wake_delay) else $error("wake load not after switch delay");
    property p_wake_pc;
        wakeInterrupt && !cpuRun && quiet && !highPriorityIntEnable && !lowPriorityIntEnable
            |-> ##5 pcValue == $past(currentPc, 5) + `PC_STEP;
    endproperty
    a_wake_pc: assert property (p_wake_pc) else $error("interrupt wake pc wrong");
    property p_wdt_wake;
        watchdogTimeout && !cpuRun && quiet |-> ##5 (loadPc && pcValue == $past(currentPc, 5) + `PC_STEP);
    endproperty
    a_wdt_wake: assert property (p_wdt_wake) else $error("watchdog wake pc wrong");
    property p_reset_pc;
        powerOnReset || brownoutReset || externalResetPin || resetInstruction |=> loadPc && pcValue == `PC_RESET;
    endproperty
    a_reset_pc: assert property (p_reset_pc) else $error("reset did not load zero");
    property p_stack_pc;
        (stackOverflow && stackFaultResetEnable) || stackUnderflow |=> loadPc && pcValue == `PC_RESET;
    endproperty
    a_stack_pc: assert property (p_stack_pc) else $error("stack fault did not load zero");
    property p_periph_hold;
        !peripheralClockOn |-> !cpuRun && !secondaryOscStarted;
    endproperty
    a_periph_hold: assert property (p_periph_hold) else $error("peripheral clock held wrongly");
    property p_pri_idle;
        $fell(cpuRun) && primaryOscOn |=> (primaryOscOn && peripheralClockOn) [*3];
    endproperty
    a_pri_idle: assert property (p_pri_idle) else $error("primary clock stopped in idle");
    property p_sec_switch;
        $rose(peripheralOnSecondary) |-> !primaryOscOn;
    endproperty
    a_sec_switch: assert property (p_sec_switch) else $error("primary still on after switch");
endmodule

// File: idle_mode_and_reset_cause_logic_bench.sv
// Self-checking bench for the idle mode and reset cause logic
`include "idle_reset_consts.svh"
module idle_mode_and_reset_cause_logic_bench
    import idle_reset_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clock = 1'b0, nrst = 1'b0, sleepMode = 1'b0, stackFaultResetEnable = 1'b0;
    logic        highPriorityIntEnable = 1'b0, lowPriorityIntEnable = 1'b0, primaryOscStable = 1'b1;
    logic        secondaryOscEnable = 1'b0, secondaryOscStarted = 1'b1, regWrite = 1'b0, regRead = 1'b0;
    logic [11:0] regAddr = 12'h000;
    byte_t       regWrData = 8'h00;
    byte_t       regRdData;
    pc_t         currentPc = 21'h001234;
    pc_t         pcValue;
    logic        cpuRun, peripheralClockOn, peripheralOnSecondary, primaryOscOn, loadPc;
    logic [8:0]  ev = 9'h000;
    wire         powerOnReset, brownoutReset, externalResetPin, resetInstruction, watchdogTimeout;
    wire         stackOverflow, stackUnderflow, wakeInterrupt, haltInstruction;
    int          err_count = 0;
    int          tests_run = 0;
    assign {haltInstruction, wakeInterrupt, stackUnderflow, stackOverflow, watchdogTimeout,
            resetInstruction, externalResetPin, brownoutReset, powerOnReset} = ev;
    always #2.5 clock = ~clock;
    idle_mode_and_reset_cause_logic idle_mode_and_reset_cause_logic_i
    (
        .clock                 (clock),
        .nrst                  (nrst),
        .powerOnReset          (powerOnReset),
        .brownoutReset         (brownoutReset),
        .externalResetPin      (externalResetPin),
        .resetInstruction      (resetInstruction),
        .watchdogTimeout       (watchdogTimeout),
        .stackOverflow         (stackOverflow),
        .stackUnderflow        (stackUnderflow),
        .stackFaultResetEnable (stackFaultResetEnable),
        .haltInstruction       (haltInstruction),
        .sleepMode             (sleepMode),
        .wakeInterrupt         (wakeInterrupt),
        .highPriorityIntEnable (highPriorityIntEnable),
        .lowPriorityIntEnable  (lowPriorityIntEnable),
        .secondaryOscEnable    (secondaryOscEnable),
        .secondaryOscStarted   (secondaryOscStarted),
        .primaryOscStable      (primaryOscStable),
        .currentPc             (currentPc),
        .regWrite              (regWrite),
        .regRead               (regRead),
        .regAddr               (regAddr),
        .regWrData             (regWrData),
        .regRdData             (regRdData),
        .cpuRun                (cpuRun),
        .peripheralClockOn     (peripheralClockOn),
        .peripheralOnSecondary (peripheralOnSecondary),
        .primaryOscOn          (primaryOscOn),
        .loadPc                (loadPc),
        .pcValue               (pcValue)
    );
    task check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            err_count++;
            $display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task close_out;
        $display("Comparisons %0d, mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    // One-cycle event pulse: 0 power-on, 1 brown-out, 2 pin, 3 reset instruction, 4 watchdog,
    // 5 overflow, 6 underflow, 7 wake, 8 halt
    task fire(input int k);
        @(negedge clock);
        ev = 9'h001 << k;
        @(negedge clock);
        ev = 9'h000;
    endtask
    task wr(input logic [11:0] a, input byte_t d);
        @(negedge clock);
        regWrite = 1'b1;
        regAddr = a;
        regWrData = d;
        @(negedge clock);
        regWrite = 1'b0;
    endtask
    task rd(input logic [11:0] a, input byte_t m, input byte_t e);
        @(negedge clock);
        regRead = 1'b1;
        regAddr = a;
        @(negedge clock);
        regRead = 1'b0;
        check(regRdData & m, e);
    endtask
    task waitLoad;
        int i;
        for (i = 0; i < 40 && loadPc !== 1'b1; i++)
            @(negedge clock);
        if (loadPc !== 1'b1)
        begin
            err_count++;
            $display("MISMATCH at %0t: no pc load", $time);
            close_out();
        end
    endtask
    task step(input int k, input logic [11:0] a, input byte_t m, input byte_t e);
        fire(k);
        waitLoad();
        check(pcValue, `PC_RESET);
        rd(a, m, e);
    endtask
    initial
    begin
        repeat (6) @(negedge clock);
        nrst = 1'b1;
        rd(`ADDR_RESET_CAUSE, 8'h1f, 8'h1c);
        wr(12'hf00, 8'hff);
        rd(12'hf00, 8'hff, 8'h00);
        wr(`ADDR_WATCHDOG, 8'ha5);
        rd(`ADDR_WATCHDOG, 8'hff, 8'ha5);
        wr(`ADDR_RESET_CAUSE, 8'h13);
        rd(`ADDR_RESET_CAUSE, 8'h1f, 8'h1f);
        step(3, `ADDR_RESET_CAUSE, 8'h1f, 8'h0f);
        step(4, `ADDR_RESET_CAUSE, 8'h1f, 8'h07);
        step(1, `ADDR_RESET_CAUSE, 8'h1f, 8'h1e);
        step(2, `ADDR_RESET_CAUSE, 8'h1f, 8'h1e);
        secondaryOscEnable = 1'b1;
        wr(`ADDR_CLOCK_MODE, 8'h01);
        step(4, `ADDR_RESET_CAUSE, 8'h1f, 8'h16);
        step(2, `ADDR_RESET_CAUSE, 8'h1f, 8'h1e);
        sleepMode = 1'b1;
        step(2, `ADDR_RESET_CAUSE, 8'h1f, 8'h1a);
        sleepMode = 1'b0;
        stackFaultResetEnable = 1'b1;
        step(5, `ADDR_STACK_PTR, 8'hc0, 8'h80);
        stackFaultResetEnable = 1'b0;
        step(6, `ADDR_STACK_PTR, 8'hc0, 8'hc0);
        fire(5);
        check(loadPc, 1'b0);
        step(0, `ADDR_RESET_CAUSE, 8'h1f, 8'h1c);
        rd(`ADDR_STACK_PTR, 8'hc0, 8'h00);
        wr(`ADDR_CLOCK_MODE, 8'h00);
        fire(8);
        check(cpuRun, 1'b1);
        wr(`ADDR_CLOCK_MODE, 8'h81);
        wr(`ADDR_CLOCK_MODE, 8'h80);
        fire(8);
        check(cpuRun, 1'b0);
        check(primaryOscOn & peripheralClockOn, 1'b1);
        rd(`ADDR_CLOCK_MODE, 8'h8f, 8'h88);
        fire(7);
        waitLoad();
        check(pcValue, currentPc + `PC_STEP);
        check(cpuRun, 1'b1);
        rd(`ADDR_CLOCK_MODE, 8'h8f, 8'h88);
        rd(`ADDR_RESET_CAUSE, 8'h1f, 8'h18);
        for (int v = 0; v < 2; v++)
        begin
            highPriorityIntEnable = (v == 0);
            lowPriorityIntEnable = (v == 1);
            fire(8);
            fire(7);
            waitLoad();
            check(pcValue, v ? `PC_VEC_LOW : `PC_VEC_HIGH);
        end
        highPriorityIntEnable = 1'b0;
        lowPriorityIntEnable = 1'b0;
        secondaryOscEnable = 1'b0;
        wr(`ADDR_CLOCK_MODE, 8'h81);
        fire(8);
        check(cpuRun, 1'b1);
        secondaryOscEnable = 1'b1;
        secondaryOscStarted = 1'b0;
        fire(8);
        check(cpuRun, 1'b0);
        check(peripheralClockOn, 1'b0);
        check(primaryOscOn, 1'b0);
        secondaryOscStarted = 1'b1;
        @(negedge clock);
        check(peripheralClockOn & peripheralOnSecondary, 1'b1);
        rd(`ADDR_CLOCK_MODE, 8'h8f, 8'h85);
        fire(4);
        waitLoad();
        check(pcValue, currentPc + `PC_STEP);
        check(cpuRun & peripheralOnSecondary, 1'b1);
        rd(`ADDR_RESET_CAUSE, 8'h1f, 8'h10);
        rd(`ADDR_CLOCK_MODE, 8'h8f, 8'h85);
        close_out();
    end
endmodule
bind idle_mode_and_reset_cause_logic idle_reset_checker idle_reset_checker_i
(
    .clock                 (clock),
    .nrst                  (nrst),
    .powerOnReset          (powerOnReset),
    .brownoutReset         (brownoutReset),
    .externalResetPin      (externalResetPin),
    .resetInstruction      (resetInstruction),
    .watchdogTimeout       (watchdogTimeout),
    .stackOverflow         (stackOverflow),
    .stackUnderflow        (stackUnderflow),
    .stackFaultResetEnable (stackFaultResetEnable),
    .wakeInterrupt         (wakeInterrupt),
    .highPriorityIntEnable (highPriorityIntEnable),
    .lowPriorityIntEnable  (lowPriorityIntEnable),
    .secondaryOscStarted   (secondaryOscStarted),
    .currentPc             (currentPc),
    .cpuRun                (cpuRun),
    .peripheralClockOn     (peripheralClockOn),
    .peripheralOnSecondary (peripheralOnSecondary),
    .primaryOscOn          (primaryOscOn),
    .loadPc                (loadPc),
    .pcValue               (pcValue)
);
